// [design/aof_regs.svh]
// Offsets, field positions and serial-port constants of the converter back end
`ifndef AOF_REGS_SVH
`define AOF_REGS_SVH

// Output word layout
`define AOF_WORD_W          32
`define AOF_RES_MSB         31
`define AOF_RES_LSB         8
`define AOF_OVR_BIT         2
`define AOF_RES_W           24

// Serial port framing
`define AOF_SYNC_FILL       8'hFF
`define AOF_SYNC_TERM       8'hFE
`define AOF_SYNC_FILL_CNT   15
`define AOF_SYNC_ONES       (`AOF_SYNC_FILL_CNT * 8 + 7)
`define AOF_CMD_CONVERT     8'hC0
`define AOF_EXIT_BYTE       8'hFF
`define AOF_FLAG_CLKS       8
`define AOF_WORD_CLKS       32

// Code limits, unipolar full scale is 2^24 sample LSBs
`define AOF_UNI_MAX         24'hFFFFFF
`define AOF_BIP_MAX         24'h7FFFFF
`define AOF_BIP_MIN         24'h800000

// Nominal master clock in Hz, filter timing scales with it
`define AOF_MCLK_NOM_HZ     4915200

`endif

// [design/aof_pkg.sv]
// Types shared by the converter back end
package aof_pkg;

    typedef enum logic [1:0] {
        PORT_CMD,
        PORT_WAIT,
        PORT_FLAG,
        PORT_SHIFT
    } aof_port_e;

    typedef logic [3:0] aof_rate_t;

endpackage

// [design/aof_fifo.sv]
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
module aof_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 32
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  almost_full
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;

    wire  [AW:0]      count = wr_ptr - rd_ptr;
    wire              push  = in_valid & in_ready;
    wire              pop   = out_valid & out_ready;

    assign in_ready    = count != (AW+1)'(DEPTH);
    assign out_valid   = count != '0;
    assign out_data    = mem[rd_ptr[AW-1:0]];
    // Two slots of margin cover the registered ready upstream
    assign almost_full = count >= (AW+1)'(DEPTH - 2);

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end

endmodule

// [design/aof_sinc3.sv]
// Third-order sinc decimator with power-of-two ratio
`timescale 1ns/1ps
module aof_sinc3 #(
    parameter int IN_W      = 26,
    parameter int MAX_LOG2D = 9
) (
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    input  wire logic                   in_valid,
    input  wire logic signed [IN_W-1:0] in_data,
    input  wire logic        [3:0]      log2d,
    output logic                        out_valid,
    output logic signed      [IN_W-1:0] out_data
);

    localparam int ACC_W = IN_W + 3 * MAX_LOG2D;

    logic signed [ACC_W-1:0]     integ [3];
    logic signed [ACC_W-1:0]     dly   [3];
    logic        [MAX_LOG2D-1:0] dcnt;
    logic                        dec_tick;

    wire signed  [ACC_W-1:0]     int_src [4];
    wire signed  [ACC_W-1:0]     cmb     [4];
    wire         [MAX_LOG2D-1:0] dlim  = MAX_LOG2D'((1 << log2d) - 1);
    wire         [5:0]           shamt = 6'(3 * log2d);

    assign int_src[0] = ACC_W'(in_data);
    assign cmb[0]     = integ[2];

    // Integrators at input rate, differentiators at decimated rate
    for (genvar k = 0; k < 3; k++) begin : g_stage
        assign int_src[k+1] = integ[k];
        assign cmb[k+1]     = cmb[k] - dly[k];

        always_ff @(posedge core_clk) begin
            if (!rstn) begin
                integ[k] <= '0;
            end else if (in_valid) begin
                integ[k] <= integ[k] + int_src[k];
            end
        end

        always_ff @(posedge core_clk) begin
            if (!rstn) begin
                dly[k] <= '0;
            end else if (dec_tick) begin
                dly[k] <= cmb[k];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dcnt     <= '0;
            dec_tick <= 1'b0;
        end else begin
            dec_tick <= in_valid && (dcnt == dlim);
            if (in_valid) begin
                dcnt <= (dcnt == dlim) ? '0 : dcnt + 1'b1;
            end
        end
    end

    // Gain of D cubed removed by shift
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            out_valid <= dec_tick;
            if (dec_tick) begin
                out_data <= IN_W'(cmb[3] >>> shamt);
            end
        end
    end

endmodule

// [design/aof_conv_port.sv]
// Output word formatting, decimation chain and serial read port
//
// Overview of operation
// - 24-bit result in 32-bit word, MSB first
// - Word bits 31..8 hold latest result
// - Bit 2 flags over-range input
// - Bits 7..3 and 1..0 read zero
// - Straight binary unipolar, two's complement bipolar
// - Unipolar codes clamp to 000000..FFFFFF
// - Bipolar codes clamp to 800000..7FFFFF
// - Fastest rate (code 8) bypasses the third-order stage
// - Other rates cascade a programmable third-order stage
// - Ratio is base rate over word rate
// - All filter timing follows the master clock
// - Fifteen fill bytes plus terminator restore command mode
// - Chip select high ignores clocks, floats output
// - Read is 8 flag clocks plus 32 data
`timescale 1ns/1ps
`include "aof_regs.svh"
module aof_conv_port #(
    parameter int SMP_W      = 26,
    parameter int FIFO_DEPTH = 32,
    parameter int MAX_LOG2D  = 9
) (
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire logic                      smp_valid,
    input  wire logic signed [SMP_W-1:0]   smp_data,
    output logic                           smp_ready,
    input  wire aof_pkg::aof_rate_t        output_word_rate,
    input  wire logic                      filter_rate_select,
    input  wire logic                      bipolar,
    input  wire logic                      cs_n,
    input  wire logic                      sclk,
    input  wire logic                      sdi,
    output logic                           sdo,
    output logic                           sdo_oe,
    output logic [`AOF_WORD_W-1:0]         conversion_result,
    output logic                           data_ready
);

    //**********************************************************************
    // Decimation ratio
    //**********************************************************************

    // Both base rates give the same ratio per rate code
    function automatic logic [3:0] rate_to_log2d(input aof_pkg::aof_rate_t code);
        logic [3:0] r;
        r = 4'h5;
        unique case (code)
            4'h0:    r = 4'h5;
            4'h1:    r = 4'h6;
            4'h2:    r = 4'h7;
            4'h3:    r = 4'h8;
            4'h4:    r = 4'h9;
            4'h8:    r = 4'h0;
            4'h9:    r = 4'h1;
            4'hA:    r = 4'h2;
            4'hB:    r = 4'h3;
            4'hC:    r = 4'h4;
            default: r = 4'h5;
        endcase
        return r;
    endfunction

    // Ratio = 3840/rate or 3200/rate; same code table for either base
    wire [3:0] log2d    = rate_to_log2d(output_word_rate);
    wire       base_sel = filter_rate_select;
    wire       bypass   = (log2d == 4'h0);

    //**********************************************************************
    // Sample FIFO
    //**********************************************************************

    logic                    fifo_in_ready;
    logic                    fifo_valid;
    logic signed [SMP_W-1:0] fifo_data;
    logic                    fifo_afull;
    logic                    drain_ok;

    wire fifo_push = smp_valid & smp_ready;
    wire fifo_pop  = fifo_valid & drain_ok;

    aof_fifo #(
        .WIDTH (SMP_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .in_valid    (fifo_push),
        .in_ready    (fifo_in_ready),
        .in_data     (smp_data),
        .out_valid   (fifo_valid),
        .out_ready   (drain_ok),
        .out_data    (fifo_data),
        .almost_full (fifo_afull)
    );

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            smp_ready <= 1'b0;
        end else begin
            smp_ready <= ~fifo_afull & fifo_in_ready;
        end
    end

    //**********************************************************************
    // Third-order stage
    //**********************************************************************

    logic                    s3_valid;
    logic signed [SMP_W-1:0] s3_data;

    // Stage runs on core_clk, so rates scale with the master clock
    aof_sinc3 #(
        .IN_W      (SMP_W),
        .MAX_LOG2D (MAX_LOG2D)
    ) u_sinc3 (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_valid  (fifo_pop & ~bypass),
        .in_data   (fifo_data),
        .log2d     (log2d),
        .out_valid (s3_valid),
        .out_data  (s3_data)
    );

    wire                    filt_valid = (bypass ? fifo_pop : s3_valid) & drain_ok;
    wire signed [SMP_W-1:0] filt_data  = bypass ? fifo_data : s3_data;

    //**********************************************************************
    // Output coding
    //**********************************************************************

    localparam logic signed [SMP_W-1:0] UNI_MAX = SMP_W'(`AOF_UNI_MAX);
    localparam logic signed [SMP_W-1:0] BIP_MAX = SMP_W'(`AOF_BIP_MAX);
    localparam logic signed [SMP_W-1:0] BIP_MIN = -SMP_W'(`AOF_BIP_MIN);

    // Bipolar LSB spans twice the unipolar LSB
    wire signed [SMP_W-1:0] bip_val  = filt_data >>> 1;
    wire                    uni_hi   = filt_data > UNI_MAX;
    wire                    uni_lo   = filt_data < 0;
    wire                    bip_hi   = bip_val > BIP_MAX;
    wire                    bip_lo   = bip_val < BIP_MIN;

    wire [`AOF_RES_W-1:0] uni_code =
        uni_hi ? `AOF_UNI_MAX : (uni_lo ? 24'h000000 : filt_data[`AOF_RES_W-1:0]);
    wire [`AOF_RES_W-1:0] bip_code =
        bip_hi ? `AOF_BIP_MAX : (bip_lo ? `AOF_BIP_MIN : bip_val[`AOF_RES_W-1:0]);

    wire [`AOF_RES_W-1:0] res_code = bipolar ? bip_code : uni_code;
    wire                  res_ovr  = bipolar ? (bip_hi | bip_lo) : (uni_hi | uni_lo);

    logic [`AOF_WORD_W-1:0] next_word;

    always_comb begin
        next_word                                = '0;
        next_word[`AOF_RES_MSB:`AOF_RES_LSB]     = res_code;
        next_word[`AOF_OVR_BIT]                  = res_ovr;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            conversion_result <= '0;
        end else if (filt_valid) begin
            conversion_result <= next_word;
        end
    end

    //**********************************************************************
    // Serial port
    //**********************************************************************

    aof_pkg::aof_port_e state;
    aof_pkg::aof_port_e next_state;
    logic               sclk_q;
    logic [5:0]         bit_cnt;
    logic [7:0]         rx_byte;
    logic [6:0]         one_cnt;
    logic               exit_req;
    logic [31:0]        tx_word;
    logic               next_sdo;

    // Clock edges only count while selected
    wire       sel        = ~cs_n;
    wire       sclk_rise  = sel & sclk & ~sclk_q;
    wire       sclk_fall  = sel & ~sclk & sclk_q;
    wire [7:0] next_byte  = {rx_byte[6:0], sdi};
    wire       byte_end   = sclk_rise && (bit_cnt == 6'd7);
    wire       word_end   = sclk_rise && (bit_cnt == 6'(`AOF_WORD_CLKS - 1));
    wire       sync_hit   = sclk_rise && !sdi && (one_cnt == 7'(`AOF_SYNC_ONES));
    wire       in_cmd     = state == aof_pkg::PORT_CMD;
    wire       in_flag    = state == aof_pkg::PORT_FLAG;
    wire       in_shift   = state == aof_pkg::PORT_SHIFT;
    wire       start_conv = in_cmd && byte_end && (next_byte == `AOF_CMD_CONVERT);
    wire       take_word  = in_flag && byte_end;
    wire       ready_clr  = take_word | start_conv;

    // Result stays frozen while it is being shifted out
    assign drain_ok = ~(in_flag | in_shift);

    always_comb begin
        next_state = state;
        if (sync_hit) begin
            next_state = aof_pkg::PORT_CMD;
        end else begin
            unique case (state)
                aof_pkg::PORT_CMD: begin
                    if (start_conv) begin
                        next_state = aof_pkg::PORT_WAIT;
                    end
                end
                aof_pkg::PORT_WAIT: begin
                    if (data_ready) begin
                        next_state = aof_pkg::PORT_FLAG;
                    end
                end
                aof_pkg::PORT_FLAG: begin
                    if (byte_end) begin
                        next_state = aof_pkg::PORT_SHIFT;
                    end
                end
                aof_pkg::PORT_SHIFT: begin
                    if (word_end) begin
                        next_state = exit_req ? aof_pkg::PORT_CMD : aof_pkg::PORT_WAIT;
                    end
                end
            endcase
        end
    end

    always_comb begin
        next_sdo = sdo;
        unique case (state)
            aof_pkg::PORT_CMD:   next_sdo = 1'b1;
            aof_pkg::PORT_WAIT:  next_sdo = ~data_ready;
            aof_pkg::PORT_FLAG:  next_sdo = 1'b0;
            aof_pkg::PORT_SHIFT: next_sdo = sclk_fall ? tx_word[31] : sdo;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state  <= aof_pkg::PORT_CMD;
            sclk_q <= 1'b0;
        end else begin
            state  <= next_state;
            sclk_q <= sclk;
        end
    end

    // Bit counter restarts on each word, each sync and each byte outside the shift state
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bit_cnt <= '0;
        end else if (sync_hit || next_state != state) begin
            bit_cnt <= '0;
        end else if (sclk_rise && !(state == aof_pkg::PORT_WAIT)) begin
            bit_cnt <= byte_end && !in_shift ? '0 : bit_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rx_byte <= '0;
            one_cnt <= '0;
        end else if (sclk_rise) begin
            rx_byte <= next_byte;
            if (!sdi) begin
                one_cnt <= '0;
            end else if (one_cnt != 7'(`AOF_SYNC_ONES)) begin
                one_cnt <= one_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            exit_req <= 1'b0;
            tx_word  <= '0;
        end else if (take_word) begin
            exit_req <= next_byte == `AOF_EXIT_BYTE;
            tx_word  <= conversion_result;
        end else if (in_shift && sclk_fall) begin
            tx_word  <= {tx_word[30:0], 1'b0};
        end
    end

    // New result wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            data_ready <= 1'b0;
        end else begin
            data_ready <= filt_valid | (data_ready & ~ready_clr);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sdo    <= 1'b1;
            sdo_oe <= 1'b0;
        end else begin
            sdo    <= next_sdo;
            sdo_oe <= sel;
        end
    end

    // Base select is unused; it alters neither the ratio nor any timing
    wire unused_base = base_sel;

endmodule

// [verif/aof_conv_port_assertions.sv]
// Port checker for the converter back end
`timescale 1ns/1ps
`include "aof_regs.svh"
module aof_conv_port_checker #(
    parameter int SMP_W      = 26,
    parameter int FIFO_DEPTH = 32,
    parameter int MAX_LOG2D  = 9
) (
    input wire logic                    core_clk,
    input wire logic                    rstn,
    input wire logic                    smp_valid,
    input wire logic signed [SMP_W-1:0] smp_data,
    input wire logic                    smp_ready,
    input wire aof_pkg::aof_rate_t      output_word_rate,
    input wire logic                    filter_rate_select,
    input wire logic                    bipolar,
    input wire logic                    cs_n,
    input wire logic                    sclk,
    input wire logic                    sdi,
    input wire logic                    sdo,
    input wire logic                    sdo_oe,
    input wire logic [`AOF_WORD_W-1:0]  conversion_result,
    input wire logic                    data_ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire logic [23:0] code = conversion_result[31:8];
    wire logic        ovr  = conversion_result[2];

    property p_pad_zero;
        conversion_result[7:3] == 5'h00 && conversion_result[1:0] == 2'h0;
    endproperty
    property p_oe_cs;
        sdo_oe == !$past(cs_n);
    endproperty
    property p_ovr_uni;
        $changed(conversion_result) && !$past(bipolar) && ovr |->
            code == `AOF_UNI_MAX || code == 24'h0;
    endproperty
    property p_ovr_bip;
        $changed(conversion_result) && $past(bipolar) && ovr |->
            code == `AOF_BIP_MAX || code == `AOF_BIP_MIN;
    endproperty
    property p_result_ready;
        $changed(conversion_result) |-> data_ready;
    endproperty
    property p_clear_serial;
        $fell(data_ready) |-> !$past(cs_n) || !$past(cs_n, 2);
    endproperty
    property p_sdo_stands;
        !cs_n && $rose(sclk) |-> $stable(sdo) ##1 $stable(sdo);
    endproperty
    property p_ready_rst;
        $rose(rstn) |-> !smp_ready ##1 smp_ready;
    endproperty

    a_pad_zero: assert property (p_pad_zero) else $error("pad bits set");
    a_oe_cs: assert property (p_oe_cs) else $error("output enable off chip select");
    a_ovr_uni: assert property (p_ovr_uni) else $error("unipolar flag without clamp");
    a_ovr_bip: assert property (p_ovr_bip) else $error("bipolar flag without clamp");
    a_result_ready: assert property (p_result_ready) else $error("word without ready");
    a_clear_serial: assert property (p_clear_serial) else $error("ready cleared idle");
    a_sdo_stands: assert property (p_sdo_stands) else $error("output moved at clock rise");
    a_ready_rst: assert property (p_ready_rst) else $error("fifo ready after reset");

    c_refused: cover property (smp_valid && !smp_ready);
    c_flag_clear: cover property ($fell(data_ready));
    c_ovr: cover property ($changed(conversion_result) && ovr);
endmodule

bind aof_conv_port aof_conv_port_checker #(
    .SMP_W(SMP_W), .FIFO_DEPTH(FIFO_DEPTH), .MAX_LOG2D(MAX_LOG2D)
) chk_u (
    .core_clk, .rstn, .smp_valid, .smp_data, .smp_ready, .output_word_rate,
    .filter_rate_select, .bipolar, .cs_n, .sclk, .sdi, .sdo, .sdo_oe,
    .conversion_result, .data_ready
);

// [verif/aof_host_model.sv]
// Host controller model driving the serial port
`timescale 1ns/1ps
`include "aof_regs.svh"
module aof_host_model #(
    parameter int HALF       = 4,
    parameter int START_WAIT = 64
) (
    input  wire logic core_clk,
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end
    task automatic half();
        repeat (HALF) @(posedge core_clk);
        #1;
    endtask
    // Chip select only moves with the clock low
    task automatic select();
        cs_n = 1'b0;
        half();
    endtask
    task automatic deselect();
        half();
        cs_n = 1'b1;
        sdi  = ~sdi;
    endtask
    // Data set while low, output sampled as clock rises
    task automatic bit_clk(input logic b, output logic s);
        sdi = b;
        half();
        s    = sdo;
        sclk = 1'b1;
        half();
        sclk = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] tx);
        logic s;
        for (int i = 7; i >= 0; i--) bit_clk(tx[i], s);
    endtask
    task automatic sync();
        repeat (START_WAIT) @(posedge core_clk);
        #1;
        select();
        repeat (`AOF_SYNC_FILL_CNT) send_byte(`AOF_SYNC_FILL);
        send_byte(`AOF_SYNC_TERM);
    endtask
    // Eight flag clocks, then the word MSB first
    task automatic read_frame(input logic [7:0] flag, output logic [31:0] w);
        logic       s;
        logic [7:0] f;
        f = flag;
        for (int i = 0; i < 40; i++) begin
            bit_clk(f[7], s);
            f = f << 1;
            if (i >= 8) w = {w[30:0], s};
        end
    endtask
    task automatic ghost_clocks(input int n);
        cs_n = 1'b1;
        repeat (n) begin
            half();
            sclk = 1'b1;
            sdi  = ~sdi;
            half();
            sclk = 1'b0;
        end
        cs_n = 1'b0;
        half();
    endtask
    task automatic wait_flag(output logic ok);
        int n = 0;
        while (sdo !== 1'b0 && n < 4000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        ok = (sdo === 1'b0);
    endtask
endmodule

// [verif/test_aof_conv_port.sv]
// Testbench for the converter back end
`timescale 1ns/1ps
`include "aof_regs.svh"
module test_aof_conv_port;
    logic                      core_clk           = 1'b0;
    logic                      rstn               = 1'b0;
    logic                      smp_valid          = 1'b0;
    logic signed [25:0]        smp_data           = 26'sh0;
    aof_pkg::aof_rate_t        output_word_rate   = 4'h8;
    logic                      filter_rate_select = 1'b0;
    logic                      bipolar            = 1'b0;
    logic                      smp_ready, cs_n, sclk, sdi, sdo, sdo_oe, data_ready;
    logic [31:0]               conversion_result;
    int                        errors             = 0;
    int                        compares           = 0;

    always #12.5 core_clk = ~core_clk;

    aof_conv_port dut_u (
        .core_clk(core_clk), .rstn(rstn), .smp_valid(smp_valid), .smp_data(smp_data),
        .smp_ready(smp_ready), .output_word_rate(output_word_rate),
        .filter_rate_select(filter_rate_select), .bipolar(bipolar), .cs_n(cs_n),
        .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .conversion_result(conversion_result), .data_ready(data_ready)
    );
    // Floating output seen as inverted level
    aof_host_model host_u (
        .core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .sdo(sdo_oe ? sdo : ~sdo)
    );

    // ************
    // Helpers
    // ************
    function automatic logic [31:0] exp_word(logic signed [25:0] s, logic bip);
        logic signed [26:0] h;
        logic               o;
        h = bip ? 27'(s >>> 1) : 27'(s) - 27'sh0800000;
        o = h < -27'sh0800000 || h > 27'sh07FFFFF;
        if (h < -27'sh0800000) h = -27'sh0800000;
        if (h > 27'sh07FFFFF) h = 27'sh07FFFFF;
        return {bip ? h[23] : ~h[23], h[22:0], 5'h00, o, 2'h0};
    endfunction
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic push(logic signed [25:0] s);
        int n = 0;
        smp_data  = s;
        smp_valid = 1'b1;
        while (smp_ready !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        #1;
    endtask
    task automatic expect_word(logic [31:0] exp);
        int n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (conversion_result !== exp && n < 100);
        chk("conversion_result", exp, conversion_result);
    endtask
    task automatic close_out();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ************
    // Scenarios
    // ************
    task automatic t_reset();
        chk("reset state", 32'h9, {28'h0, conversion_result === 32'h0, data_ready, sdo_oe,
            smp_ready});
    endtask
    task automatic t_codes();
        logic signed [25:0] tbl [12] = '{26'sh0800000, 26'sh0, 26'sh1, 26'sh0FFFFFF,
            26'sh1000000, -26'sh1, 26'sh0, -26'sh2, 26'sh0FFFFFE, 26'sh1000000,
            -26'sh1000000, -26'sh1000002};
        for (int i = 0; i < 12; i++) begin
            bipolar = (i >= 6);
            push(tbl[i]);
            smp_valid = 1'b0;
            expect_word(exp_word(tbl[i], bipolar));
        end
    endtask
    task automatic t_sinc3();
        aof_pkg::aof_rate_t rt [6] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'h0, 4'h4};
        int                 dn [6] = '{8, 16, 32, 64, 128, 2048};
        logic signed [25:0] v  [6] = '{26'sh0200000, 26'sh0A00000, 26'sh0F00000,
            26'sh0500000, 26'sh0300000, 26'sh0700000};
        bipolar = 1'b0;
        for (int k = 0; k < 6; k++) begin
            output_word_rate   = rt[k];
            filter_rate_select = k[0];
            repeat (dn[k]) push(v[k]);
            smp_valid = 1'b0;
            expect_word(exp_word(v[k], 1'b0));
        end
        output_word_rate = 4'h8;
    endtask
    task automatic t_read();
        logic [31:0] w;
        logic        ok;
        int          acc = 0;
        host_u.sync();
        host_u.send_byte(`AOF_CMD_CONVERT);
        push(26'sh0123456);
        smp_valid = 1'b0;
        host_u.wait_flag(ok);
        chk("ready flag", 32'h1, {31'h0, ok});
        smp_data  = 26'sh0654321;
        smp_valid = 1'b1;
        repeat (40) begin
            ok = smp_ready;
            @(posedge core_clk);
            #1;
            acc += ok;
        end
        smp_valid = 1'b0;
        chk("fifo fill", 32'h1, {31'h0, acc >= 30 && acc <= 32});
        chk("fifo refuse", 32'h0, {31'h0, smp_ready});
        host_u.ghost_clocks(40);
        chk("ready kept", 32'h1, {31'h0, data_ready});
        host_u.read_frame(`AOF_EXIT_BYTE, w);
        chk("read word", exp_word(26'sh0123456, 1'b0), w);
        host_u.deselect();
        repeat (2) @(posedge core_clk);
        #1;
        chk("sdo_oe", 32'h0, {31'h0, sdo_oe});
        expect_word(exp_word(26'sh0654321, 1'b0));
        chk("fifo drained", 32'h1, {31'h0, smp_ready});
    endtask
    task automatic t_resync();
        logic [31:0] w;
        logic        ok;
        host_u.select();
        host_u.send_byte(`AOF_CMD_CONVERT);
        push(26'sh0222222);
        smp_valid = 1'b0;
        host_u.wait_flag(ok);
        host_u.sync();
        host_u.send_byte(`AOF_CMD_CONVERT);
        push(26'sh0333333);
        smp_valid = 1'b0;
        host_u.wait_flag(ok);
        host_u.read_frame(`AOF_EXIT_BYTE, w);
        chk("word after sync", exp_word(26'sh0333333, 1'b0), w);
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        t_reset();
        t_codes();
        t_sinc3();
        t_read();
        t_resync();
        close_out();
    end
    initial begin
        #(25 * 30000);
        errors++;
        close_out();
    end
endmodule
